// >>> verilog/adc_pkg.sv
// Constants and types for the asynchronous DMA context control block
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package adc_pkg;
    localparam int ADC_NCTX = 4;
    localparam int ADC_ADDR_W = 12;
    // Register byte offsets, one entry per context
    localparam logic [11:0] ADC_SET_OFS [4] = '{12'h180, 12'h1A0, 12'h1C0, 12'h1E0};
    localparam logic [11:0] ADC_CLR_OFS [4] = '{12'h184, 12'h1A4, 12'h1C4, 12'h1E4};
    localparam logic [11:0] ADC_PTR_OFS [4] = '{12'h18C, 12'h1AC, 12'h1CC, 12'h1EC};
    // Control word field positions
    localparam int ADC_RUN_BIT = 15;
    localparam int ADC_WAKE_BIT = 12;
    localparam int ADC_DEAD_BIT = 11;
    localparam int ADC_ACT_BIT = 10;
    localparam int ADC_SPD_LSB = 5;
    localparam int ADC_EVT_LSB = 0;
    localparam logic [31:0] ADC_CTRL_RMASK = 32'h0000_9CFF;
    // Command pointer field positions
    localparam int ADC_PTR_ADDR_LSB = 4;
    localparam int ADC_PTR_CNT_W = 4;
    // Speed codes
    localparam logic [2:0] ADC_SPD_100 = 3'h0;
    localparam logic [2:0] ADC_SPD_200 = 3'h1;
    localparam logic [2:0] ADC_SPD_400 = 3'h2;
    // Values after reset
    localparam logic [31:0] ADC_PTR_RST = 32'h0000_0000;
    localparam logic [4:0] ADC_EVT_RST = 5'h00;
    localparam logic [2:0] ADC_SPD_RST = ADC_SPD_100;
    // First receive context index
    localparam int ADC_RX_FIRST = 2;
    localparam int ADC_FIFO_DEPTH = 8;
    // Completion record: ctx, fatal, speed, event, next pointer
    localparam int ADC_REC_W = 43;
    // Bus responses
    localparam logic [1:0] ADC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ADC_RESP_DECERR = 2'h3;
    // Decode kinds
    localparam logic [1:0] ADC_K_SET = 2'h0;
    localparam logic [1:0] ADC_K_CLR = 2'h1;
    localparam logic [1:0] ADC_K_PTR = 2'h2;

    typedef enum logic [1:0] {
        ADC_ST_IDLE = 2'b00,
        ADC_ST_FETCH = 2'b01,
        ADC_ST_WAIT = 2'b10,
        ADC_ST_STALL = 2'b11
    } adc_state_type;
endpackage

// >>> verilog/adc_fifo.sv
// Completion record FIFO with valid and ready on both sides
`timescale 1ns/1ps
module adc_fifo #(
    parameter int WIDTH = 43,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic in_ready_r;
    logic push;
    logic pop;

    // Pointer step with wrap at any depth
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Handshakes and level
    assign push = in_valid && in_ready_r;
    assign pop = out_valid && out_ready;
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign in_ready = in_ready_r;
    assign count_nxt = count_r + CW'(push) - CW'(pop);

    // Storage, no reset needed
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers, count and registered ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready_r <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= step(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= step(rd_ptr_r);
            end
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != CW'(DEPTH));
        end
    end
endmodule

// >>> verilog/adc_ctrl.sv
// Asynchronous DMA context control, status and command pointers with AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module adc_ctrl #(
    parameter int FIFO_DEPTH = adc_pkg::ADC_FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic fetch_valid,
    input wire logic fetch_ready,
    output logic [1:0] fetch_ctx,
    output logic [31:0] fetch_addr,
    output logic [3:0] fetch_count,
    input wire logic cmp_valid,
    output logic cmp_ready,
    input wire logic [1:0] cmp_ctx,
    input wire logic cmp_fatal,
    input wire logic [2:0] cmp_spd,
    input wire logic [4:0] cmp_evt,
    input wire logic [31:0] cmp_ptr
);
    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    localparam int N = adc_pkg::ADC_NCTX;

    adc_pkg::adc_state_type st_r [N];
    logic [N-1:0] run_r;
    logic [N-1:0] wake_r;
    logic [N-1:0] dead_r;
    logic [2:0] spd_r [N];
    logic [4:0] evt_r [N];
    logic [31:0] ptr_r [N];

    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic fv_r;
    logic [1:0] fctx_r;
    logic [31:0] faddr_r;
    logic [3:0] fcnt_r;

    logic wr_go;
    logic [4:0] wdec;
    logic [4:0] rdec;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] rd_word;
    logic [N-1:0] set_run;
    logic [N-1:0] clr_run;
    logic [N-1:0] set_wake;
    logic [N-1:0] ptr_wr;
    logic [N-1:0] taken;
    logic [N-1:0] rec_hit;
    logic pick_ok;
    logic [1:0] pick;

    logic rec_valid;
    logic rec_ready;
    logic pop;
    logic [adc_pkg::ADC_REC_W-1:0] rec;
    logic [1:0] rec_ctx;
    logic rec_fatal;
    logic [2:0] rec_spd;
    logic [4:0] rec_evt;
    logic [31:0] rec_ptr;

    //--------------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------------
    // Address decode: {hit, kind, context}
    function automatic logic [4:0] decode(input logic [11:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int n = 0; n < N; n++) begin
            if (a[11:2] == adc_pkg::ADC_SET_OFS[n][11:2]) begin
                r = {1'b1, adc_pkg::ADC_K_SET, 2'(n)};
            end
            if (a[11:2] == adc_pkg::ADC_CLR_OFS[n][11:2]) begin
                r = {1'b1, adc_pkg::ADC_K_CLR, 2'(n)};
            end
            if (a[11:2] == adc_pkg::ADC_PTR_OFS[n][11:2]) begin
                r = {1'b1, adc_pkg::ADC_K_PTR, 2'(n)};
            end
        end
        return r;
    endfunction

    // Descriptor count field of a pointer
    function automatic logic [3:0] zcount(input logic [31:0] p);
        return p[adc_pkg::ADC_PTR_CNT_W-1:0];
    endfunction

    // Active while fetching or awaiting completion
    function automatic logic is_active(input adc_pkg::adc_state_type s);
        return (s == adc_pkg::ADC_ST_FETCH) || (s == adc_pkg::ADC_ST_WAIT);
    endfunction

    //--------------------------------------------------------------------
    // Completion record buffer
    //--------------------------------------------------------------------
    adc_fifo #(
        .WIDTH(adc_pkg::ADC_REC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(cmp_valid),
        .in_ready(cmp_ready),
        .in_data({cmp_ctx, cmp_fatal, cmp_spd, cmp_evt, cmp_ptr}),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data(rec)
    );

    // Register writes take priority; the buffer drains otherwise
    assign rec_ready = !wr_go;
    assign pop = rec_valid && rec_ready;
    assign {rec_ctx, rec_fatal, rec_spd, rec_evt, rec_ptr} = rec;

    //--------------------------------------------------------------------
    // Software events from the write channel
    //--------------------------------------------------------------------
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    assign wdec = decode(waddr_r);
    assign rdec = decode(s_axi_araddr);
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wbits = wdata_r & wmask;

    // Per-context strobes; ones written to set or clear ports act
    always_comb begin
        for (int n = 0; n < N; n++) begin
            logic hit;
            hit = wr_go && wdec[4] && (wdec[1:0] == 2'(n));
            set_run[n] = hit && (wdec[3:2] == adc_pkg::ADC_K_SET) && wbits[adc_pkg::ADC_RUN_BIT];
            clr_run[n] = hit && (wdec[3:2] == adc_pkg::ADC_K_CLR) && wbits[adc_pkg::ADC_RUN_BIT];
            set_wake[n] = hit && (wdec[3:2] == adc_pkg::ADC_K_SET) && wbits[adc_pkg::ADC_WAKE_BIT];
            ptr_wr[n] = hit && (wdec[3:2] == adc_pkg::ADC_K_PTR);
            taken[n] = fv_r && fetch_ready && (fctx_r == 2'(n));
            rec_hit[n] = pop && (rec_ctx == 2'(n));
        end
    end

    //--------------------------------------------------------------------
    // Run bit: only software or reset changes it
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn || soft_reset) begin
                run_r[n] <= 1'b0;
            end else if (clr_run[n]) begin
                run_r[n] <= 1'b0;
            end else if (set_run[n]) begin
                run_r[n] <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------
    // Wake bit: a set in the fetch cycle survives the clear
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn || soft_reset) begin
                wake_r[n] <= 1'b0;
            end else begin
                wake_r[n] <= (wake_r[n] && !taken[n]) || set_wake[n];
            end
        end
    end

    //--------------------------------------------------------------------
    // Fatal error flag: set wins over a run clear in the same cycle
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn || soft_reset) begin
                dead_r[n] <= 1'b0;
            end else begin
                dead_r[n] <= (dead_r[n] && !clr_run[n]) || (rec_hit[n] && rec_fatal);
            end
        end
    end

    //--------------------------------------------------------------------
    // Completion status: event code always, speed for receive contexts
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn) begin
                evt_r[n] <= adc_pkg::ADC_EVT_RST;
                spd_r[n] <= adc_pkg::ADC_SPD_RST;
            end else if (rec_hit[n]) begin
                evt_r[n] <= rec_evt;
                if (n >= adc_pkg::ADC_RX_FIRST) begin
                    spd_r[n] <= rec_spd;
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // Command pointers: byte-wise software writes, device advance
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn) begin
                ptr_r[n] <= adc_pkg::ADC_PTR_RST;
            end else if (ptr_wr[n]) begin
                ptr_r[n] <= (ptr_r[n] & ~wmask) | wbits;
            end else if (rec_hit[n]) begin
                ptr_r[n] <= rec_ptr;
            end
        end
    end

    //--------------------------------------------------------------------
    // Context state machines
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        for (int n = 0; n < N; n++) begin
            if (!aresetn || soft_reset) begin
                st_r[n] <= adc_pkg::ADC_ST_IDLE;
            end else if (clr_run[n]) begin
                st_r[n] <= adc_pkg::ADC_ST_IDLE;
            end else begin
                case (st_r[n])
                    adc_pkg::ADC_ST_IDLE: begin
                        // Start only on a run transition from zero
                        if (set_run[n] && !run_r[n]) begin
                            if (zcount(ptr_r[n]) == 4'h0) begin
                                st_r[n] <= adc_pkg::ADC_ST_STALL;
                            end else begin
                                st_r[n] <= adc_pkg::ADC_ST_FETCH;
                            end
                        end
                    end
                    adc_pkg::ADC_ST_FETCH: begin
                        if (taken[n]) begin
                            st_r[n] <= adc_pkg::ADC_ST_WAIT;
                        end
                    end
                    adc_pkg::ADC_ST_WAIT: begin
                        if (rec_hit[n]) begin
                            if (rec_fatal) begin
                                st_r[n] <= adc_pkg::ADC_ST_IDLE;
                            end else if (zcount(rec_ptr) == 4'h0) begin
                                st_r[n] <= adc_pkg::ADC_ST_STALL;
                            end else begin
                                st_r[n] <= adc_pkg::ADC_ST_FETCH;
                            end
                        end
                    end
                    adc_pkg::ADC_ST_STALL: begin
                        // Reload the pointer only on a wake request
                        if (wake_r[n] && zcount(ptr_r[n]) != 4'h0) begin
                            st_r[n] <= adc_pkg::ADC_ST_FETCH;
                        end
                    end
                    default: begin
                        st_r[n] <= adc_pkg::ADC_ST_IDLE;
                    end
                endcase
            end
        end
    end

    //--------------------------------------------------------------------
    // Fetch request: lowest numbered context waiting to fetch
    //--------------------------------------------------------------------
    always_comb begin
        pick_ok = 1'b0;
        pick = 2'h0;
        for (int n = N - 1; n >= 0; n--) begin
            if (st_r[n] == adc_pkg::ADC_ST_FETCH) begin
                pick_ok = 1'b1;
                pick = 2'(n);
            end
        end
    end

    // Request held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fv_r <= 1'b0;
            fctx_r <= 2'h0;
            faddr_r <= 32'h0000_0000;
            fcnt_r <= 4'h0;
        end else if (fv_r) begin
            if (fetch_ready) begin
                fv_r <= 1'b0;
            end
        end else if (pick_ok) begin
            fv_r <= 1'b1;
            fctx_r <= pick;
            faddr_r <= {ptr_r[pick][31:adc_pkg::ADC_PTR_ADDR_LSB], 4'h0};
            fcnt_r <= zcount(ptr_r[pick]);
        end
    end

    assign fetch_valid = fv_r;
    assign fetch_ctx = fctx_r;
    assign fetch_addr = faddr_r;
    assign fetch_count = fcnt_r;

    //--------------------------------------------------------------------
    // Read data mux; both control ports return the same word
    //--------------------------------------------------------------------
    always_comb begin
        logic [31:0] cw;
        cw = 32'h0000_0000;
        rd_word = 32'h0000_0000;
        cw[adc_pkg::ADC_RUN_BIT] = run_r[rdec[1:0]];
        cw[adc_pkg::ADC_WAKE_BIT] = wake_r[rdec[1:0]];
        cw[adc_pkg::ADC_DEAD_BIT] = dead_r[rdec[1:0]];
        cw[adc_pkg::ADC_ACT_BIT] = is_active(st_r[rdec[1:0]]);
        cw[adc_pkg::ADC_SPD_LSB +: 3] = spd_r[rdec[1:0]];
        cw[adc_pkg::ADC_EVT_LSB +: 5] = evt_r[rdec[1:0]];
        if (rdec[4]) begin
            if (rdec[3:2] == adc_pkg::ADC_K_PTR) begin
                rd_word = ptr_r[rdec[1:0]];
            end else begin
                rd_word = cw & adc_pkg::ADC_CTRL_RMASK;
            end
        end
    end

    //--------------------------------------------------------------------
    // AXI4-Lite write channel
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= adc_pkg::ADC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
                waddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wdec[4] ? adc_pkg::ADC_RESP_OKAY : adc_pkg::ADC_RESP_DECERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------
    // AXI4-Lite read channel
    //--------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= adc_pkg::ADC_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rdec[4] ? adc_pkg::ADC_RESP_OKAY : adc_pkg::ADC_RESP_DECERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// >>> dv/adc_ctrl_assertions.sv
// Port-level checks for the context control block
`timescale 1ns/1ps
module adc_ctrl_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fetch_valid,
    input wire logic fetch_ready,
    input wire logic [31:0] fetch_addr,
    input wire logic [3:0] fetch_count
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus handshakes and control-port reads
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_ctrl;
        s_rd ##0 (s_axi_araddr[11:7] == 5'h03 && s_axi_araddr[4:0] inside {5'h00, 5'h04});
    endsequence
    AST_B_LATENCY: assert property (s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_RSV_ZERO: assert property (s_rd_ctrl |=> (s_axi_rdata & ~adc_pkg::ADC_CTRL_RMASK) == 32'h0)
        else $error("reserved control bits set");
    AST_DECERR: assert property (s_rd ##0 s_axi_araddr < 12'h180 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_FETCH_HOLD: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr))
        else $error("fetch request changed");
    AST_FETCH_ALIGN: assert property (fetch_valid |-> fetch_addr[3:0] == 4'h0 && fetch_count != 4'h0)
        else $error("bad fetch address or count");
    AST_FETCH_GAP: assert property (fetch_valid && fetch_ready |=> !fetch_valid)
        else $error("fetch requests back to back");
endmodule

bind adc_ctrl adc_ctrl_assertions i_adc_chk (.*);

// >>> dv/adc_fetch_model.sv
// Behavioural fetch engine returning one completion record per fetch
`timescale 1ns/1ps
module adc_fetch_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fetch_valid,
    output logic fetch_ready,
    input wire logic [1:0] fetch_ctx,
    input wire logic [31:0] fetch_addr,
    input wire logic [3:0] fetch_count,
    output logic cmp_valid,
    input wire logic cmp_ready,
    output logic [1:0] cmp_ctx,
    output logic cmp_fatal,
    output logic [2:0] cmp_spd,
    output logic [4:0] cmp_evt,
    output logic [31:0] cmp_ptr,
    input wire logic [31:0] m_ptr,
    input wire logic m_fatal,
    output logic [31:0] seen_ptr
);
    // Receive contexts are answered slowly; fatal, event and pointer fields invert once released
    initial begin
        {fetch_ready, cmp_valid, cmp_ctx, cmp_fatal, cmp_spd, cmp_evt, cmp_ptr, seen_ptr} = '0;
        forever begin
            @(posedge aclk);
            if (aresetn && fetch_valid) begin
                repeat (fetch_ctx[1] ? 2 : 0) @(posedge aclk);
                fetch_ready <= 1'b1;
                @(posedge aclk);
                fetch_ready <= 1'b0;
                seen_ptr <= fetch_addr | 32'(fetch_count);
                cmp_valid <= 1'b1;
                cmp_ctx <= fetch_ctx;
                cmp_spd <= {1'b0, fetch_ctx[0], ~fetch_ctx[0]};
                {cmp_fatal, cmp_evt, cmp_ptr} <= {m_fatal, 3'h4, fetch_ctx, m_ptr};
                @(posedge aclk iff cmp_ready);
                cmp_valid <= 1'b0;
                {cmp_fatal, cmp_evt, cmp_ptr} <= ~{cmp_fatal, cmp_evt, cmp_ptr};
            end
        end
    end
endmodule

// >>> dv/async_dma_context_control_tb_top.sv
// Self-checking bench for the asynchronous DMA context control block
`timescale 1ns/1ps
module async_dma_context_control_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, soft_reset = 1'b0, m_fatal = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, cmp_spd;
    logic [3:0] s_axi_wstrb = 4'hF, fetch_count;
    logic [31:0] s_axi_wdata = 32'h0, m_ptr = 32'h0, s_axi_rdata, fetch_addr, cmp_ptr, seen_ptr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic fetch_valid, fetch_ready, cmp_valid, cmp_ready, cmp_fatal;
    logic [1:0] s_axi_bresp, s_axi_rresp, fetch_ctx, cmp_ctx;
    logic [4:0] cmp_evt;
    int errors = 0, cmp_count = 0;
    // Clock and design instances
    always #20 aclk = ~aclk;
    adc_ctrl i_dut (.*);
    adc_fetch_model i_model (.*);
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Register write, each channel released when taken; bready comes late to exercise the hold
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        fork
            begin @(posedge aclk iff s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin @(posedge aclk iff s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        @(posedge aclk iff s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk iff s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(r));
    endtask
    // Register read with expected word and response; rready comes late to exercise the hold
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk iff s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk iff s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, e);
        check(32'(s_axi_rresp), 32'(r));
    endtask
    // Run takes well under 1000 cycles
    initial begin
        #50us;
        errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h18C, 32'h0, 2'h0);
        rd(12'h180, 32'h0, 2'h0);
        rd(12'h100, 32'h0, 2'h3);
        wr(12'h1F0, 32'hFFFF_FFFF, 2'h3);
        m_ptr <= 32'h0000_5670;
        for (int n = 0; n < 4; n++) begin
            wr(adc_pkg::ADC_PTR_OFS[n], 32'h0000_1232 + (n << 8), 2'h0);
            rd(adc_pkg::ADC_PTR_OFS[n], 32'h0000_1232 + (n << 8), 2'h0);
            wr(adc_pkg::ADC_SET_OFS[n], 32'hFFFF_EFFF, 2'h0);
            repeat (12) @(posedge aclk);
            check(seen_ptr, 32'h0000_1232 + (n << 8));
            rd(adc_pkg::ADC_CLR_OFS[n], 32'h0000_8010 + n + (n == 2 ? 32 : n == 3 ? 64 : 0), 2'h0);
            rd(adc_pkg::ADC_PTR_OFS[n], 32'h0000_5670, 2'h0);
        end
        {m_ptr, m_fatal} <= {32'h0000_4441, 1'b1};
        wr(12'h18C, 32'h0000_7771, 2'h0);
        wr(12'h180, 32'h0000_1000, 2'h0);
        repeat (12) @(posedge aclk);
        check(seen_ptr, 32'h0000_7771);
        rd(12'h184, 32'h0000_8810, 2'h0);
        wr(12'h184, 32'h0000_8000, 2'h0);
        rd(12'h180, 32'h0000_0010, 2'h0);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        rd(12'h1C4, 32'h0000_0032, 2'h0);
        stop_test();
    end
endmodule
